//--- verilog/vomr_pkg.sv
// vomr_pkg: constants, field positions and routing codes for the output
// routing and teletext control register of the video encoder.
// assumes a register access port giving an 8-bit address and data.
package vomr_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] VOMR_ROUTE_ADDR     = 8'h03;
  localparam logic [7:0] VOMR_ROUTE_RST      = 8'h00;
  localparam logic [7:0] VOMR_ROUTE_WMASK    = 8'hFC;
  localparam logic [1:0] VOMR_REVISION_DEF   = 2'h0; // value arbitrary

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int VOMR_REV_LSB   = 0;
  localparam int VOMR_REV_MSB   = 1;
  localparam int VOMR_VBI_OPEN  = 2;
  localparam int VOMR_DAC_ARR   = 3;
  localparam int VOMR_CHROMA_A  = 4;
  localparam int VOMR_TTX_EN    = 5;
  localparam int VOMR_TTX_STYLE = 6;
  localparam int VOMR_ZERO_COL  = 7;

  // ----------------------------------------------------------------------
  // dac signal selection codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    VOMR_SIG_CVBS  = 3'h0,
    VOMR_SIG_LUMA  = 3'h1,
    VOMR_SIG_CHROM = 3'h2,
    VOMR_SIG_GREEN = 3'h3,
    VOMR_SIG_BLUE  = 3'h4,
    VOMR_SIG_RED   = 3'h5,
    VOMR_SIG_PB    = 3'h6,
    VOMR_SIG_PR    = 3'h7
  } vomr_sig_t;

  localparam logic [7:0] VOMR_PIX_ZERO  = 8'h00;
  localparam logic [7:0] VOMR_PIX_BLACK = 8'h10;
endpackage : vomr_pkg

//--- verilog/vomr_route_reg.sv
// vomr_route_reg: output routing and teletext control register with the
// dac routing matrix, vbi pass gating, teletext gating and zero pixel fix.
// assumes synchronous inputs on clk and the next mode and timing bits
// coming from their own registers elsewhere in the encoder.
//
// Overview of operation
// - an eight-bit control register sits at address 03h.
// - bits one and zero give a fixed revision and ignore writes.
// - vbi data passes to the outputs when the vbi open bit is set.
// - vbi data is never passed while in slave timing mode 0.
// - a used blank input wins over vbi open and stops vbi passing.
// - the dac arrangement bit puts luma or green on dac a for euroscart.
// - the extra chroma bit replaces composite on dac a with chroma.
// - teletext is inserted only when the insert enable bit is one.
// - teletext request is steady high in style 0, per bit in style 1.
// - zero pixel input shows its own colour or is forced to black.
// - composite mode gives cvbs on b, chroma on c, ypbpr bit ignored.
// - rgb mode gives blue on b and red on c, dac a cvbs or green.
// - ypbpr mode gives pb on b and pr on c, dac a cvbs or luma.
// - the component output select bit picks composite or component.
// - the ypbpr select bit picks ypbpr over rgb in component mode.
// - the blank input use bit decides if blank is honoured in slave mode.
`timescale 1ns/100ps
`default_nettype none
module vomr_route_reg
  import vomr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       component_output_select_bit,
  input  wire logic       ypbpr_select_bit,
  input  wire logic       blank_input_use_bit,
  input  wire logic       slave_mode,
  input  wire logic       slave_timing_mode0,
  input  wire logic       vbi_active,
  input  wire logic       blank_in_n,
  input  wire logic       teletext_data_input,
  input  wire logic       teletext_bit_slot,
  input  wire logic [7:0] pixel_in,
  output logic      [2:0] dac_a_sel,
  output logic      [2:0] dac_b_sel,
  output logic      [2:0] dac_c_sel,
  output logic            vbi_pass,
  output logic            blank_out,
  output logic            teletext_insert,
  output logic            teletext_bit,
  output logic            teletext_request_output,
  output logic      [7:0] pixel_out
);
  // ----------------------------------------------------------------------
  // register
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic       hit;
  logic       blank_used;
  logic       a_alt;
  logic       a_base;
  logic       vbi_pass_nxt;
  logic       blank_nxt;
  logic       ttx_ins_nxt;
  logic       ttx_bit_nxt;
  logic [7:0] pix_nxt;
  logic [2:0] a_nxt;
  logic [2:0] b_nxt;
  logic [2:0] c_nxt;

  assign hit      = (reg_addr == VOMR_ROUTE_ADDR);
  assign ctrl_nxt = (hit && reg_wr) ? (reg_wdata & VOMR_ROUTE_WMASK)
                                    : ctrl_r;
  assign reg_rdata = hit ? {ctrl_r[VOMR_ZERO_COL:VOMR_VBI_OPEN],
                            VOMR_REVISION_DEF} : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= VOMR_ROUTE_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // dac routing
  // ----------------------------------------------------------------------
  assign a_alt  = ctrl_r[VOMR_DAC_ARR];
  assign a_base = ctrl_r[VOMR_CHROMA_A];
  assign a_nxt  = a_alt ? ((component_output_select_bit && !ypbpr_select_bit)
                           ? VOMR_SIG_GREEN : VOMR_SIG_LUMA)
                : (a_base ? VOMR_SIG_CHROM : VOMR_SIG_CVBS);
  assign b_nxt  = !component_output_select_bit ? VOMR_SIG_CVBS
                : (ypbpr_select_bit ? VOMR_SIG_PB : VOMR_SIG_BLUE);
  assign c_nxt  = !component_output_select_bit ? VOMR_SIG_CHROM
                : (ypbpr_select_bit ? VOMR_SIG_PR : VOMR_SIG_RED);

  // ----------------------------------------------------------------------
  // vbi, blank, teletext and pixel path
  // ----------------------------------------------------------------------
  assign blank_used   = slave_mode && blank_input_use_bit;
  assign vbi_pass_nxt = vbi_active && ctrl_r[VOMR_VBI_OPEN]
                        && !slave_timing_mode0 && !blank_used;
  assign blank_nxt    = (vbi_active && !vbi_pass_nxt)
                        || (blank_used && !blank_in_n);
  assign ttx_ins_nxt  = ctrl_r[VOMR_TTX_EN];
  assign ttx_bit_nxt  = ctrl_r[VOMR_TTX_EN] && teletext_data_input;
  assign teletext_request_output = ctrl_r[VOMR_TTX_EN]
         && (!ctrl_r[VOMR_TTX_STYLE] || teletext_bit_slot);
  assign pix_nxt = (ctrl_r[VOMR_ZERO_COL] && pixel_in == VOMR_PIX_ZERO)
                   ? VOMR_PIX_BLACK : pixel_in;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_a_sel       <= VOMR_SIG_CVBS;
      dac_b_sel       <= VOMR_SIG_CVBS;
      dac_c_sel       <= VOMR_SIG_CHROM;
      vbi_pass        <= 1'b0;
      blank_out       <= 1'b0;
      teletext_insert <= 1'b0;
      teletext_bit    <= 1'b0;
      pixel_out       <= VOMR_PIX_ZERO;
    end else begin
      dac_a_sel       <= a_nxt;
      dac_b_sel       <= b_nxt;
      dac_c_sel       <= c_nxt;
      vbi_pass        <= vbi_pass_nxt;
      blank_out       <= blank_nxt;
      teletext_insert <= ttx_ins_nxt;
      teletext_bit    <= ttx_bit_nxt;
      pixel_out       <= pix_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_write_val;
    hit && reg_wr;
  endsequence

  property p_rev_fixed;
    @(posedge clk) disable iff (!arst_n)
      hit |-> reg_rdata[VOMR_REV_MSB:VOMR_REV_LSB] == VOMR_REVISION_DEF;
  endproperty
  a_rev_fixed: assert property (p_rev_fixed)
    else $error("revision bits changed");

  property p_readback;
    @(posedge clk) disable iff (!arst_n)
      s_write_val ##1 (hit && !reg_wr)
        |-> (reg_rdata & VOMR_ROUTE_WMASK)
            == ($past(reg_wdata) & VOMR_ROUTE_WMASK);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback differs from write");

  property p_mode0_novbi;
    @(posedge clk) disable iff (!arst_n)
      slave_timing_mode0 |=> !vbi_pass;
  endproperty
  a_mode0_novbi: assert property (p_mode0_novbi)
    else $error("vbi passed in slave mode 0");

  property p_blank_wins;
    @(posedge clk) disable iff (!arst_n)
      (slave_mode && blank_input_use_bit) |=> !vbi_pass;
  endproperty
  a_blank_wins: assert property (p_blank_wins)
    else $error("vbi passed while blank input used");

  property p_vbi_open;
    @(posedge clk) disable iff (!arst_n)
      (vbi_active && ctrl_r[VOMR_VBI_OPEN] && !slave_timing_mode0
       && !slave_mode) |=> vbi_pass;
  endproperty
  a_vbi_open: assert property (p_vbi_open)
    else $error("vbi not passed when open");

  property p_ttx_gate;
    @(posedge clk) disable iff (!arst_n)
      !ctrl_r[VOMR_TTX_EN] |=> !teletext_insert && !teletext_bit;
  endproperty
  a_ttx_gate: assert property (p_ttx_gate)
    else $error("teletext inserted while disabled");

  property p_ttx_req;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_r[VOMR_TTX_EN] && !ctrl_r[VOMR_TTX_STYLE])
        |-> teletext_request_output;
  endproperty
  a_ttx_req: assert property (p_ttx_req)
    else $error("request not steady high");

  property p_black;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_r[VOMR_ZERO_COL] && pixel_in == VOMR_PIX_ZERO)
        |=> pixel_out == VOMR_PIX_BLACK;
  endproperty
  a_black: assert property (p_black)
    else $error("zero pixel not forced black");

  property p_comp_route;
    @(posedge clk) disable iff (!arst_n)
      !component_output_select_bit
        |=> dac_b_sel == VOMR_SIG_CVBS && dac_c_sel == VOMR_SIG_CHROM;
  endproperty
  a_comp_route: assert property (p_comp_route)
    else $error("composite routing wrong");

  property p_rgb_route;
    @(posedge clk) disable iff (!arst_n)
      (component_output_select_bit && !ypbpr_select_bit)
        |=> dac_b_sel == VOMR_SIG_BLUE && dac_c_sel == VOMR_SIG_RED;
  endproperty
  a_rgb_route: assert property (p_rgb_route)
    else $error("rgb routing wrong");

  property p_euro_a;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_r[VOMR_DAC_ARR] && !component_output_select_bit)
        |=> dac_a_sel == VOMR_SIG_LUMA;
  endproperty
  a_euro_a: assert property (p_euro_a)
    else $error("dac a not luma in euroscart");

  property p_chroma_a;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_r[VOMR_CHROMA_A] && !ctrl_r[VOMR_DAC_ARR])
        |=> dac_a_sel == VOMR_SIG_CHROM;
  endproperty
  a_chroma_a: assert property (p_chroma_a)
    else $error("dac a not chroma");
endmodule : vomr_route_reg
`default_nettype wire

//--- sim/vomr_ttx_src.sv
// vomr_ttx_src: teletext source model feeding the encoder data pin.
// assumes the block's request output and the bench clock.
`timescale 1ns/100ps
`default_nettype none
module vomr_ttx_src (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic req,
  output logic      data
);
  logic [7:0] pat_r;
  // ---------------------------------------------------------------
  // bits only while requested, else inverse of the last bit
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pat_r <= 8'hA7;
      data  <= 1'b0;
    end else if (req) begin
      pat_r <= {pat_r[6:0], pat_r[7]};
      data  <= pat_r[7];
    end else begin
      data <= ~data;
    end
  end
endmodule : vomr_ttx_src
`default_nettype wire

//--- sim/tb_top.sv
// tb_top: bench for the output routing and teletext control register.
// assumes vomr_pkg, vomr_route_reg and the teletext source model.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import vomr_pkg::*;
;
  logic clk, arst_n, reg_wr, component_output_select_bit, ypbpr_select_bit;
  logic blank_input_use_bit, slave_mode, slave_timing_mode0, vbi_active;
  logic blank_in_n, teletext_data_input, teletext_bit_slot, vbi_pass;
  logic blank_out, teletext_insert, teletext_bit, teletext_request_output;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pixel_in, pixel_out;
  logic [2:0] dac_a_sel, dac_b_sel, dac_c_sel, ea, eb, ec;
  logic       prev;
  int         n_fail, total_checks, cyc;
  // dac a code per row of the routing matrix, index {chroma,comp,ypbpr,arr}
  localparam vomr_sig_t mat_a [16] = '{
    VOMR_SIG_CVBS, VOMR_SIG_LUMA, VOMR_SIG_CVBS, VOMR_SIG_LUMA,
    VOMR_SIG_CVBS, VOMR_SIG_GREEN, VOMR_SIG_CVBS, VOMR_SIG_LUMA,
    VOMR_SIG_CHROM, VOMR_SIG_LUMA, VOMR_SIG_CHROM, VOMR_SIG_LUMA,
    VOMR_SIG_CHROM, VOMR_SIG_GREEN, VOMR_SIG_CHROM, VOMR_SIG_LUMA};

  vomr_route_reg i_dut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .component_output_select_bit, .ypbpr_select_bit,
    .blank_input_use_bit, .slave_mode, .slave_timing_mode0, .vbi_active,
    .blank_in_n, .teletext_data_input, .teletext_bit_slot, .pixel_in,
    .dac_a_sel, .dac_b_sel, .dac_c_sel, .vbi_pass, .blank_out,
    .teletext_insert, .teletext_bit, .teletext_request_output, .pixel_out);
  vomr_ttx_src i_src (.clk, .arst_n, .req(teletext_request_output),
    .data(teletext_data_input));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stl;
    repeat (2) @(posedge clk);
    #1;
  endtask : stl

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr   <= 1'b0;
    reg_addr <= VOMR_ROUTE_ADDR;
    stl();
  endtask : wr_reg

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {arst_n, reg_wr, reg_wdata, pixel_in, teletext_bit_slot} = '0;
    {component_output_select_bit, ypbpr_select_bit, vbi_active} = '0;
    {blank_input_use_bit, slave_mode, slave_timing_mode0} = '0;
    blank_in_n = 1'b1;
    reg_addr = VOMR_ROUTE_ADDR;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    stl();
    chk(reg_rdata, 8'h00);
    chk(8'(dac_a_sel), 8'(VOMR_SIG_CVBS));
    chk(8'(dac_b_sel), 8'(VOMR_SIG_CVBS));
    chk(8'(dac_c_sel), 8'(VOMR_SIG_CHROM));
    wr_reg(VOMR_ROUTE_ADDR, 8'hFF);
    chk(reg_rdata, 8'hFC);
    wr_reg(8'h05, 8'h00);
    chk(reg_rdata, 8'hFC);
    @(posedge clk);
    reg_addr <= 8'h05;
    #1 chk(reg_rdata, 8'h00);
    $display("test register done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      component_output_select_bit <= i[2];
      ypbpr_select_bit <= i[1];
      wr_reg(VOMR_ROUTE_ADDR, {3'h0, i[3], i[0], 3'h0});
      ea = mat_a[i];
      eb = !i[2] ? VOMR_SIG_CVBS : (i[1] ? VOMR_SIG_PB : VOMR_SIG_BLUE);
      ec = !i[2] ? VOMR_SIG_CHROM : (i[1] ? VOMR_SIG_PR : VOMR_SIG_RED);
      chk(8'(dac_a_sel), 8'(ea));
      chk(8'({dac_b_sel, dac_c_sel}), 8'({eb, ec}));
    end
    $display("test routing done");
    @(posedge clk);
    vbi_active <= 1'b1;
    wr_reg(VOMR_ROUTE_ADDR, 8'h04);
    chk(8'({vbi_pass, blank_out}), 8'h02);
    wr_reg(VOMR_ROUTE_ADDR, 8'h00);
    chk(8'({vbi_pass, blank_out}), 8'h01);
    @(posedge clk);
    slave_timing_mode0 <= 1'b1;
    wr_reg(VOMR_ROUTE_ADDR, 8'h04);
    chk(8'(vbi_pass), 8'h00);
    @(posedge clk);
    {slave_timing_mode0, slave_mode, blank_input_use_bit} <= 3'b011;
    stl();
    chk(8'(vbi_pass), 8'h00);
    @(posedge clk);
    {vbi_active, blank_in_n} <= 2'b00;
    stl();
    chk(8'(blank_out), 8'h01);
    @(posedge clk);
    {vbi_active, blank_in_n, blank_input_use_bit} <= 3'b110;
    stl();
    chk(8'({vbi_pass, blank_out}), 8'h02);
    $display("test blanking done");
    chk(8'({teletext_insert, teletext_request_output}), 8'h00);
    wr_reg(VOMR_ROUTE_ADDR, 8'h20);
    chk(8'({teletext_insert, teletext_request_output}), 8'h03);
    wr_reg(VOMR_ROUTE_ADDR, 8'h60);
    chk(8'(teletext_request_output), 8'h00);
    @(posedge clk);
    teletext_bit_slot <= 1'b1;
    stl();
    chk(8'(teletext_request_output), 8'h01);
    prev = teletext_data_input;
    repeat (4) begin
      @(posedge clk);
      #1 chk(8'(teletext_bit), 8'(prev));
      prev = teletext_data_input;
    end
    $display("test teletext done");
    wr_reg(VOMR_ROUTE_ADDR, 8'h80);
    chk(pixel_out, VOMR_PIX_BLACK);
    @(posedge clk);
    pixel_in <= 8'h05;
    stl();
    chk(pixel_out, 8'h05);
    @(posedge clk);
    pixel_in <= 8'h00;
    wr_reg(VOMR_ROUTE_ADDR, 8'h00);
    chk(pixel_out, VOMR_PIX_ZERO);
    $display("test zero colour done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
